// *** common/sdr_pkg.sv ***
// Package for the video processing control and status register bank.
// Assumes a word-level register port fed by the serial host port deserialiser.
// Operation
// - Delay line output is asserted only while control bit 14 is set; resets low.
// - Bit 12 high forwards extracted EDH flags; low forwards the programmed flag word.
// - Bit 11 reads ancillary insertion state, high meaning disabled; host cannot write it.
// - Bit 9 high disables Level A to B conversion; resets to one.
// - Bit 8 selects active picture timing when low, SMPTE H timing when high.
// - Bit 6 high stops payload identifier packet insertion.
// - Bit 5 high passes illegal code words unchanged.
// - Bit 4 high stops EDH check correction and insertion.
// - Bit 3 high stops ancillary checksum recalculation and insertion.
// - Bit 2 high stops HD and 3G per-line check word insertion.
// - Bit 1 high stops HD and 3G line number insertion.
// - Bit 0 high stops timing reference word insertion.
// - Error bit 6 shows timing reference protection errors.
// - Error bit 4 flags checksum error, refreshed at every checksum word.
// - Checksum flag stays clear for values 000h-003h and 3FCh-3FFh.
// - Error bit 5 acts like bit 4 but updates only on EDH packets.
// - Error bit 3 shows unrecognised standard for conversion.
// - Error bit 2 shows raster timing disagreeing with payload identifier.
// - Error bit 1 shows missing incoming payload identifier packet.
// - Error bit 0 shows PLL not locked.
// - Extracted EDH word holds ancillary, full-field, active-picture groups in 14-10, 9-5, 4-0.

package sdr_pkg;

    // Register word indices on the host port
    localparam logic [11:0] ADDR_VIDEO_PROCESSING_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_ERROR_STATUS_FLAGS       = 12'h001;
    localparam logic [11:0] ADDR_EXTRACTED_EDH_FLAGS      = 12'h002;

    // Control word field positions
    localparam int CTL_DELAY_LINE_EN      = 14;
    localparam int CTL_EDH_FLAG_SOURCE    = 12;
    localparam int CTL_ANC_INSERT_OFF     = 11;
    localparam int CTL_LEVEL_AB_CONV_OFF  = 9;
    localparam int CTL_H_TIMING_SEL       = 8;
    localparam int CTL_PAYLOAD_ID_OFF     = 6;
    localparam int CTL_BAD_CODE_REMAP_OFF = 5;
    localparam int CTL_EDH_CHECK_OFF      = 4;
    localparam int CTL_ANC_CHECKSUM_OFF   = 3;
    localparam int CTL_LINE_CHECK_OFF     = 2;
    localparam int CTL_LINE_NUMBER_OFF    = 1;
    localparam int CTL_TIMING_REF_OFF     = 0;

    // Host-writable bits of the control word, and its reset value
    localparam logic [15:0] CTL_WRITE_MASK = 16'h537f;
    localparam logic [15:0] CTL_RESET      = 16'h0200;

    // Error status field positions
    localparam int ERR_TIMING_REF_PROTECT = 6;
    localparam int ERR_EDH_PACKET_CSUM    = 5;
    localparam int ERR_ANC_CSUM           = 4;
    localparam int ERR_FORMAT             = 3;
    localparam int ERR_TIMING             = 2;
    localparam int ERR_PAYLOAD_ID_MISSING = 1;
    localparam int ERR_PLL_LOCK           = 0;
    localparam logic [15:0] ERR_RESET     = 16'h0000;

    // Extracted EDH word layout
    localparam int EDH_ANC_LSB     = 10;
    localparam int EDH_FF_LSB      = 5;
    localparam int EDH_AP_LSB      = 0;
    localparam int EDH_FLAG_WIDTH  = 15;
    localparam logic [14:0] EDH_RESET = 15'h0000;

    // Protected checksum value ranges
    localparam logic [9:0] CSUM_LOW_MAX  = 10'h003;
    localparam logic [9:0] CSUM_HIGH_MIN = 10'h3fc;

    // Read return buffer depth
    localparam int RBUF_DEPTH = 2;

endpackage : sdr_pkg

// *** design/sdr_proc_regs.sv ***
// Control and status register bank of the transmitter video processing path.
// Assumes the serial host port has been deserialised into word requests on i_clock,
// and that all status inputs are synchronous to i_clock.
`timescale 1ns/1ns

module sdr_proc_regs
    import sdr_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    input  wire logic        i_clk_en,
    // Word-level host register port
    input  wire logic [11:0] i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_reg_rd,
    output logic             o_reg_rd_ready,
    output logic             o_reg_rvalid,
    output logic [15:0]      o_reg_rdata,
    input  wire logic        i_reg_rready,
    // Processing path state
    input  wire logic        i_anc_insert_off,
    input  wire logic        i_timing_ref_protect_err,
    input  wire logic        i_csum_word,
    input  wire logic [9:0]  i_csum_value,
    input  wire logic        i_csum_mismatch,
    input  wire logic        i_csum_is_edh,
    input  wire logic        i_format_err,
    input  wire logic        i_timing_err,
    input  wire logic        i_payload_id_missing_err,
    input  wire logic        i_pll_unlocked,
    input  wire logic        i_edh_ext_valid,
    input  wire logic [14:0] i_edh_ext_flags,
    input  wire logic [14:0] i_edh_pgm_flags,
    // Processing step controls
    output logic             o_delay_line_en,
    output logic             o_level_ab_conv_off,
    output logic             o_h_timing_sel,
    output logic             o_payload_id_insert_off,
    output logic             o_bad_code_remap_off,
    output logic             o_edh_check_insert_off,
    output logic             o_anc_checksum_insert_off,
    output logic             o_line_check_insert_off,
    output logic             o_line_number_insert_off,
    output logic             o_timing_ref_insert_off,
    output logic [14:0]      o_edh_flags_out
);

    logic [15:0] ctl_r;
    logic        tref_err_r;
    logic [3:0]  low_err_r;
    logic        anc_csum_err_r;
    logic        edh_csum_err_r;
    logic [15:0] err_word;
    logic [14:0] edh_ext_r;
    logic [14:0] edh_out_r;
    logic        csum_bad;

    // Read decode shared by the return buffer; unmapped words read zero
    function automatic logic [15:0] read_word(input logic [11:0] addr,
                                              input logic [15:0] ctl,
                                              input logic        anc_off,
                                              input logic [15:0] err,
                                              input logic [14:0] edh);
        logic [15:0] word;
        word = 16'h0000;
        unique case (addr)
            ADDR_VIDEO_PROCESSING_CONTROL:
            begin
                word = ctl & CTL_WRITE_MASK;
                word[CTL_ANC_INSERT_OFF] = anc_off;
            end
            ADDR_ERROR_STATUS_FLAGS:
            begin
                word = err;
            end
            ADDR_EXTRACTED_EDH_FLAGS:
            begin
                word = {1'b0, edh};
            end
            default:
            begin
                word = 16'h0000;
            end
        endcase
        return word;
    endfunction : read_word

    // Protected range check keeps reserved checksum codes from raising errors
    function automatic logic csum_protected(input logic [9:0] value);
        return (value <= CSUM_LOW_MAX) || (value >= CSUM_HIGH_MIN);
    endfunction : csum_protected

    assign csum_bad = i_csum_mismatch && !csum_protected(i_csum_value);

    // Control word: only writable bits change, bit 11 and reserved bits stay zero here
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctl_r <= CTL_RESET;
        end
        else if (i_clk_en && i_reg_wr && i_reg_addr == ADDR_VIDEO_PROCESSING_CONTROL)
        begin
            ctl_r <= i_reg_wdata & CTL_WRITE_MASK;
        end
    end

    // Level status bits follow the path on every cycle with i_clk_en high
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tref_err_r <= ERR_RESET[ERR_TIMING_REF_PROTECT];
            low_err_r  <= ERR_RESET[3:0];
        end
        else if (i_clk_en)
        begin
            tref_err_r                        <= i_timing_ref_protect_err;
            low_err_r[ERR_FORMAT]             <= i_format_err;
            low_err_r[ERR_TIMING]             <= i_timing_err;
            low_err_r[ERR_PAYLOAD_ID_MISSING] <= i_payload_id_missing_err;
            low_err_r[ERR_PLL_LOCK]           <= i_pll_unlocked;
        end
    end

    // Checksum flags hold between checksum words; the EDH one only moves on EDH packets
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            anc_csum_err_r <= ERR_RESET[ERR_ANC_CSUM];
            edh_csum_err_r <= ERR_RESET[ERR_EDH_PACKET_CSUM];
        end
        else if (i_clk_en && i_csum_word)
        begin
            anc_csum_err_r <= csum_bad;
            if (i_csum_is_edh)
            begin
                edh_csum_err_r <= csum_bad;
            end
        end
    end

    // Error word assembled from its flags; each flag has one owning process
    assign err_word = {9'h000, tref_err_r, edh_csum_err_r, anc_csum_err_r, low_err_r};

    // Extracted EDH flags captured whenever an incoming EDH packet is decoded
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            edh_ext_r <= EDH_RESET;
        end
        else if (i_clk_en && i_edh_ext_valid)
        begin
            edh_ext_r <= i_edh_ext_flags;
        end
    end

    // Outgoing EDH flag source, registered so the inserter sees a stable word
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            edh_out_r <= EDH_RESET;
        end
        else if (i_clk_en)
        begin
            edh_out_r <= ctl_r[CTL_EDH_FLAG_SOURCE] ? edh_ext_r : i_edh_pgm_flags;
        end
    end

    // Step controls straight from the control flip-flops
    assign o_delay_line_en           = ctl_r[CTL_DELAY_LINE_EN];
    assign o_level_ab_conv_off       = ctl_r[CTL_LEVEL_AB_CONV_OFF];
    assign o_h_timing_sel            = ctl_r[CTL_H_TIMING_SEL];
    assign o_payload_id_insert_off   = ctl_r[CTL_PAYLOAD_ID_OFF];
    assign o_bad_code_remap_off      = ctl_r[CTL_BAD_CODE_REMAP_OFF];
    assign o_edh_check_insert_off    = ctl_r[CTL_EDH_CHECK_OFF];
    assign o_anc_checksum_insert_off = ctl_r[CTL_ANC_CHECKSUM_OFF];
    assign o_line_check_insert_off   = ctl_r[CTL_LINE_CHECK_OFF];
    assign o_line_number_insert_off  = ctl_r[CTL_LINE_NUMBER_OFF];
    assign o_timing_ref_insert_off   = ctl_r[CTL_TIMING_REF_OFF];
    assign o_edh_flags_out           = edh_out_r;

    // Two-entry read return buffer so a stalled serialiser loses no word
    logic [15:0] rbuf_mem [RBUF_DEPTH];
    logic        wr_ptr_r;
    logic        rd_ptr_r;
    logic [1:0]  count_r;
    logic        push;
    logic        pop;

    assign o_reg_rd_ready = (count_r != 2'(RBUF_DEPTH));    // Back-pressure to the port
    assign o_reg_rvalid   = (count_r != 2'd0);
    assign push           = i_clk_en && i_reg_rd && o_reg_rd_ready;
    assign pop            = i_clk_en && o_reg_rvalid && i_reg_rready;

    // Storage written at the push pointer; no reset needed as count guards reads
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            rbuf_mem[wr_ptr_r] <= read_word(i_reg_addr, ctl_r, i_anc_insert_off,
                                            err_word, edh_ext_r);
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
            begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 2'd1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 2'd1;
            end
        end
    end

    // Head word registered in the memory; zero while empty so the bus never shows X
    assign o_reg_rdata = o_reg_rvalid ? rbuf_mem[rd_ptr_r] : 16'h0000;

endmodule : sdr_proc_regs

// *** tb/sdr_host_model.sv ***
// Host side model that drains read words.
// Assumes the bench raises i_stall to hold words back.
`timescale 1ns/1ns
module sdr_host_model
(
    input  wire logic i_clock,
    input  wire logic i_arst_n,
    input  wire logic i_stall,
    output logic      o_reg_rready
);
    // Ready moves only after an edge, like a real host
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_reg_rready <= 1'b0;
        end
        else
        begin
            o_reg_rready <= !i_stall;
        end
    end
endmodule : sdr_host_model

// *** tb/sdr_proc_regs_assertions.sv ***
// Assertions on the register bank ports.
// Assumes one clock domain; bound to every bank instance.
`timescale 1ns/1ns
module sdr_proc_regs_chk
    import sdr_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_arst_n,
    input wire logic        i_clk_en,
    input wire logic [11:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic        i_reg_rd,
    input wire logic        o_reg_rd_ready,
    input wire logic        o_reg_rvalid,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        i_timing_ref_protect_err,
    input wire logic        i_csum_word,
    input wire logic [9:0]  i_csum_value,
    input wire logic        i_format_err,
    input wire logic        i_timing_err,
    input wire logic        i_payload_id_missing_err,
    input wire logic        i_pll_unlocked,
    input wire logic        o_delay_line_en,
    input wire logic        o_level_ab_conv_off,
    input wire logic        o_h_timing_sel,
    input wire logic        o_timing_ref_insert_off
);
    // Taken control write, read into an empty buffer, status levels
    wire logic       wr0 = i_clk_en && i_reg_wr && i_reg_addr == 12'h000;
    wire logic       rde = i_clk_en && i_reg_rd && o_reg_rd_ready && !o_reg_rvalid;
    wire logic       prot = i_csum_value <= CSUM_LOW_MAX || i_csum_value >= CSUM_HIGH_MIN;
    wire logic [4:0] lv = {i_timing_ref_protect_err, i_format_err, i_timing_err,
                           i_payload_id_missing_err, i_pll_unlocked};

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    chk_delay_write: assert property (wr0 |=> o_delay_line_en == $past(i_reg_wdata[14]))
        else $error("delay enable missed a write");
    chk_conv_write: assert property (wr0 |=> o_level_ab_conv_off == $past(i_reg_wdata[9]))
        else $error("conversion off missed a write");
    chk_tref_write: assert property (wr0 |=> o_timing_ref_insert_off == $past(i_reg_wdata[0]))
        else $error("timing ref off missed a write");
    chk_ctl_hold: assert property (!wr0 |=> $stable(o_h_timing_sel))
        else $error("timing select moved without a write");
    chk_err_levels: assert property (rde && i_reg_addr == 12'h001 && $past(i_clk_en)
        && $past(i_arst_n) |=> {o_reg_rdata[6], o_reg_rdata[3:0]} == $past(lv, 2))
        else $error("error levels read wrong");
    chk_err_reserved: assert property (rde && i_reg_addr == 12'h001 |=> o_reg_rdata[15:7] == 9'h000)
        else $error("error word reserved bits set");
    chk_csum_protect: assert property (i_clk_en && i_csum_word && prot
        ##1 (i_clk_en && !i_csum_word) ##1 rde && i_reg_addr == 12'h001 |=> !o_reg_rdata[4])
        else $error("checksum flag set for protected value");
    chk_ctl_readback: assert property (rde && i_reg_addr == 12'h000 |=>
        o_reg_rdata[14] == $past(o_delay_line_en) && {o_reg_rdata[15], o_reg_rdata[13]} == 2'h0)
        else $error("control read back wrong");
endmodule : sdr_proc_regs_chk

bind sdr_proc_regs sdr_proc_regs_chk u_chk (.*);

// *** tb/sdr_proc_regs_bench.sv ***
// Self-checking bench of the register bank with a predicting model.
// Assumes the host model drains read words unless stalled.
`timescale 1ns/1ns
module sdr_proc_regs_bench
    import sdr_pkg::*;
;
    logic        i_clock, i_arst_n, i_clk_en, i_reg_wr, i_reg_rd, i_reg_rready, stall, b4, b5;
    logic        i_anc_insert_off, i_timing_ref_protect_err, i_csum_word, i_csum_mismatch;
    logic        i_csum_is_edh, i_format_err, i_timing_err, i_payload_id_missing_err;
    logic        i_pll_unlocked, i_edh_ext_valid, o_reg_rd_ready, o_reg_rvalid;
    logic        o_delay_line_en, o_level_ab_conv_off, o_h_timing_sel, o_payload_id_insert_off;
    logic        o_bad_code_remap_off, o_edh_check_insert_off, o_anc_checksum_insert_off;
    logic        o_line_check_insert_off, o_line_number_insert_off, o_timing_ref_insert_off;
    logic [9:0]  i_csum_value;
    logic [11:0] i_reg_addr;
    logic [14:0] i_edh_ext_flags, i_edh_pgm_flags, o_edh_flags_out;
    logic [15:0] i_reg_wdata, o_reg_rdata, ctl_m, exp_w;
    logic [31:0] rnd;
    int          miscompares, check_count;
    logic [9:0]  csv [6] = '{10'h000, 10'h003, 10'h004, 10'h3fb, 10'h3fc, 10'h3ff};
    // Step controls packed in the same order as the expected word
    wire logic [15:0] outs = {6'h00, o_delay_line_en, o_level_ab_conv_off, o_h_timing_sel,
        o_payload_id_insert_off, o_bad_code_remap_off, o_edh_check_insert_off,
        o_anc_checksum_insert_off, o_line_check_insert_off, o_line_number_insert_off,
        o_timing_ref_insert_off};

    sdr_proc_regs dut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
        .i_reg_rd(i_reg_rd), .o_reg_rd_ready(o_reg_rd_ready), .o_reg_rvalid(o_reg_rvalid),
        .o_reg_rdata(o_reg_rdata), .i_reg_rready(i_reg_rready),
        .i_anc_insert_off(i_anc_insert_off), .i_timing_ref_protect_err(i_timing_ref_protect_err),
        .i_csum_word(i_csum_word), .i_csum_value(i_csum_value),
        .i_csum_mismatch(i_csum_mismatch), .i_csum_is_edh(i_csum_is_edh),
        .i_format_err(i_format_err), .i_timing_err(i_timing_err),
        .i_payload_id_missing_err(i_payload_id_missing_err), .i_pll_unlocked(i_pll_unlocked),
        .i_edh_ext_valid(i_edh_ext_valid), .i_edh_ext_flags(i_edh_ext_flags),
        .i_edh_pgm_flags(i_edh_pgm_flags), .o_delay_line_en(o_delay_line_en),
        .o_level_ab_conv_off(o_level_ab_conv_off), .o_h_timing_sel(o_h_timing_sel),
        .o_payload_id_insert_off(o_payload_id_insert_off),
        .o_bad_code_remap_off(o_bad_code_remap_off),
        .o_edh_check_insert_off(o_edh_check_insert_off),
        .o_anc_checksum_insert_off(o_anc_checksum_insert_off),
        .o_line_check_insert_off(o_line_check_insert_off),
        .o_line_number_insert_off(o_line_number_insert_off),
        .o_timing_ref_insert_off(o_timing_ref_insert_off),
        .o_edh_flags_out(o_edh_flags_out));
    sdr_host_model u_host (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_stall(stall),
                           .o_reg_rready(i_reg_rready));

    // 50 MHz clock
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, g, e);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Waits, bounded, for the host to take a word, then compares it
    task automatic pop(input logic [15:0] e);
        int n;
        n = 0;
        while (!(o_reg_rvalid === 1'b1 && i_reg_rready === 1'b1) && n < 40)
        begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (!(o_reg_rvalid === 1'b1 && i_reg_rready === 1'b1))
        begin
            $display("unexpected at %0t: read word never came", $time);
            miscompares++;
            wrap_up();
        end
        chk(o_reg_rdata, e);
        @(posedge i_clock);
        #1;
    endtask : pop

    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1;
        pop(e);
    endtask : rd

    // Writes one word and checks the step controls against the model
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clock);
        {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
        if (a == 12'h000 && i_clk_en)
            ctl_m = d & 16'h537f;
        #1;
        chk(outs, {6'h00, ctl_m[14], ctl_m[9:8], ctl_m[6:0]});
    endtask : wr

    task automatic cs(input logic [9:0] v, input logic mm, input logic edh);
        @(posedge i_clock);
        {i_csum_word, i_csum_value, i_csum_mismatch, i_csum_is_edh} <= {1'b1, v, mm, edh};
        @(posedge i_clock);
        i_csum_word <= 1'b0;
        b4 = mm && !(v <= 10'h003 || v >= 10'h3fc);
        if (edh)
            b5 = b4;
    endtask : cs

    initial
    begin
        {i_arst_n, i_reg_wr, i_reg_rd, stall, i_anc_insert_off, i_timing_ref_protect_err} = '0;
        {i_csum_word, i_csum_mismatch, i_csum_is_edh, i_format_err, i_timing_err, b4, b5} = '0;
        {i_payload_id_missing_err, i_pll_unlocked, i_edh_ext_valid, miscompares, check_count} = '0;
        {i_reg_addr, i_reg_wdata, i_csum_value, i_edh_ext_flags, i_edh_pgm_flags} = '0;
        {i_clk_en, ctl_m} = {1'b1, 16'h0200};
        rnd = $urandom(29448);
        repeat (20) @(posedge i_clock);
        i_arst_n <= 1'b1;
        chk(outs, 16'h0100);
        rd(12'h000, 16'h0200);
        rd(12'h001, 16'h0000);
        rd(12'h002, 16'h0000);
        $display("test reset ended");
        for (int k = 0; k < 24; k++)
        begin
            rnd = $urandom;
            i_anc_insert_off <= rnd[16];
            wr(12'h000, k < 16 ? 16'h0001 << k : rnd[15:0]);
            rd(12'h000, ctl_m | {4'h0, rnd[16], 11'h000});
        end
        $display("test control ended");
        wr(12'h001, rnd[15:0]);
        wr(12'h002, rnd[31:16]);
        wr(12'h3ff, 16'hffff);
        i_clk_en <= 1'b0;
        wr(12'h000, ~ctl_m);
        i_clk_en <= 1'b1;
        rd(12'h3ff, 16'h0000);
        rd(12'h002, 16'h0000);
        $display("test ignored writes ended");
        for (int k = 0; k < 16; k++)
        begin
            rnd = $urandom;
            {i_timing_ref_protect_err, i_format_err, i_timing_err} <= rnd[4:2];
            {i_payload_id_missing_err, i_pll_unlocked} <= rnd[1:0];
            cs(k < 6 ? csv[k % 6] : rnd[14:5], k < 6 || rnd[15], rnd[16]);
            rd(12'h001, {9'h000, rnd[4], b5, b4, rnd[3:0]});
        end
        $display("test status ended");
        rnd = $urandom;
        {i_edh_pgm_flags, i_edh_ext_flags, i_edh_ext_valid} <= {rnd[30:16], rnd[14:0], 1'b1};
        @(posedge i_clock);
        i_edh_ext_valid <= 1'b0;
        rd(12'h002, {1'b0, rnd[14:0]});
        wr(12'h000, 16'h1000);
        @(posedge i_clock);
        #1;
        chk({1'b0, o_edh_flags_out}, {1'b0, rnd[14:0]});
        wr(12'h000, 16'h0000);
        @(posedge i_clock);
        #1;
        chk({1'b0, o_edh_flags_out}, {1'b0, rnd[30:16]});
        $display("test edh ended");
        // Host stalls: two words buffered, third request refused
        exp_w = ctl_m | {4'h0, i_anc_insert_off, 11'h000};
        stall <= 1'b1;
        @(posedge i_clock);
        {i_reg_addr, i_reg_rd} <= {12'h000, 1'b1};
        repeat (4) @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1;
        chk({15'h0000, o_reg_rd_ready}, 16'h0000);
        stall <= 1'b0;
        pop(exp_w);
        pop(exp_w);
        chk({15'h0000, o_reg_rvalid}, 16'h0000);
        $display("test buffer ended");
        wrap_up();
    end
endmodule : sdr_proc_regs_bench
